// >>> src/serial_packing_line_control.sv
// serial-to-network packing queue and terminal-ready control for one serial line
// What this block does
// - with packing on, received bytes are queued and released as one segment on threshold, or on timeout or send character per mode.
// - with packing off, each received byte is forwarded at once as its own segment.
// - in timeout mode a ms timer starts on the first byte into an empty queue, 1..30000 ms, default 1000.
// - the queue is sent as soon as its byte count reaches the threshold, 100..1450, default 512.
// - in send-character mode a byte equal to the send character releases the queue including itself.
// - any 8-bit value is a legal send character.
// - a configured trailing character is placed right after the matched send character.
// - with no trailing character configured nothing is inserted.
// - packing behaves the same whether the connection was accepted or initiated.
// - terminal-ready follows one of four policies: never, remote-following, while connected, always.
// - under the connected policy terminal-ready goes high one clock after an accept or connect link is active and low one clock after it ends.
// - under the remote-following policy it is high while a link is active and the peer reports DSR high.
// - each serial line has its own instance with its own queue and connection state.
`timescale 1ns/10ps
`include "packing_consts.svh"

module serial_packing_line_control
    import packing_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input wire logic core_clk,            // 20 MHz clock
    input wire logic reset_n,             // async reset, active low
    input wire logic rx_valid,            // received serial byte valid
    input wire logic [7:0] rx_data,       // received serial byte
    output logic rx_ready,                // block can take a byte
    output logic tx_valid,                // segment byte valid toward network
    output logic [7:0] tx_data,           // segment byte
    output logic tx_last,                 // last byte of segment
    input wire logic tx_ready,            // network path takes the byte
    input wire pack_mode_t pack_mode,     // packing mode
    input wire logic [15:0] thresh_cfg,   // threshold in bytes
    input wire logic [15:0] timeout_cfg,  // timeout in ms
    input wire logic [7:0] send_char,     // send character
    input wire logic trail_en,            // trailing character configured
    input wire logic [7:0] trail_char,    // trailing character
    input wire dtr_policy_t dtr_policy,   // terminal-ready policy
    input wire logic accept_active,       // accepted tunnel connection active
    input wire logic connect_active,      // initiated tunnel connection active
    input wire logic remote_dsr,          // peer reports DSR asserted
    output logic terminal_ready           // terminal-ready line output
);

    // out-of-range settings are pulled to the nearest legal value
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // queue and connection state live in this instance alone; one instance per serial line
    logic [7:0] queue_mem [`QUEUE_DEPTH];
    pack_state_t state;
    logic [`QUEUE_AW-1:0] count;
    logic [`QUEUE_AW-1:0] rd_ptr;
    logic [14:0] timer_ms;
    logic timer_run;
    logic [31:0] tick_cnt;
    logic ms_tick;

    logic [15:0] thresh;
    logic [15:0] timeout;
    logic accept;
    logic char_hit;
    logic thresh_hit;
    logic expire;
    logic release_now;
    logic timer_start;
    logic drain_done;
    logic [`QUEUE_AW-1:0] next_count;

    assign thresh = clamp(thresh_cfg, `THRESH_MIN, `THRESH_MAX);
    assign timeout = clamp(timeout_cfg, `TIMEOUT_MIN, `TIMEOUT_MAX);
    // connection origin never enters this logic, so accept and connect pack alike
    assign accept = rx_valid && rx_ready && state == ST_FILL;
    assign next_count = count + `QUEUE_AW'(1);
    assign char_hit = accept && pack_mode == PACK_SEND_CHAR && rx_data == send_char;
    assign thresh_hit = accept && 16'(next_count) >= thresh;
    assign expire = timer_run && ms_tick && timer_ms == 15'h0001;
    assign timer_start = accept && count == '0 && pack_mode == PACK_TIMEOUT;
    assign drain_done = state == ST_DRAIN && tx_valid && tx_ready && tx_last;

    always_comb begin
        case (pack_mode)
            PACK_TIMEOUT: release_now = thresh_hit || expire;
            PACK_SEND_CHAR: release_now = thresh_hit || char_hit;
            default: release_now = accept;
        endcase
    end

    // ms tick restarts with the timer so the first interval is a full millisecond
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else if (timer_start || tick_cnt == 32'(MS_CYCLES - 1)) begin
            tick_cnt <= 32'h0000_0000;
            ms_tick <= !timer_start;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            ms_tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_run <= 1'b0;
            timer_ms <= 15'h0000;
        end else if (release_now || state != ST_FILL) begin
            timer_run <= 1'b0;
        end else if (timer_start) begin
            timer_run <= 1'b1;
            timer_ms <= timeout[14:0];
        end else if (timer_run && ms_tick) begin
            timer_ms <= timer_ms - 15'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (accept) begin
            queue_mem[count] <= rx_data;
        end else if (state == ST_TRAIL) begin
            queue_mem[count] <= trail_char;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_FILL;
            count <= '0;
            rd_ptr <= '0;
        end else begin
            case (state)
                ST_FILL: begin
                    if (accept) begin
                        count <= next_count;
                    end
                    rd_ptr <= '0;
                    // the trailing byte wins even when the send character also meets the threshold
                    if (char_hit && trail_en) begin
                        state <= ST_TRAIL;
                    end else if (release_now) begin
                        state <= ST_DRAIN;
                    end
                end
                ST_TRAIL: begin
                    count <= next_count;
                    state <= ST_DRAIN;
                end
                ST_DRAIN: begin
                    if ((!tx_valid || tx_ready) && rd_ptr != count) begin
                        rd_ptr <= rd_ptr + `QUEUE_AW'(1);
                    end
                    if (drain_done) begin
                        count <= '0;
                        state <= ST_FILL;
                    end
                end
                default: begin
                    state <= ST_FILL;
                    count <= '0;
                end
            endcase
        end
    end

    // segment output; one byte in flight, refilled on the same edge it is taken
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else if (state == ST_DRAIN && (!tx_valid || tx_ready) && rd_ptr != count) begin
            tx_valid <= 1'b1;
            tx_data <= queue_mem[rd_ptr];
            tx_last <= rd_ptr == count - `QUEUE_AW'(1);
        end else if (tx_valid && tx_ready) begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
        end
    end

    // the serial side stalls while a segment drains; the receiver must hold its byte
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= (state == ST_FILL && !release_now && !char_hit) || drain_done;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            terminal_ready <= 1'b0;
        end else begin
            case (dtr_policy)
                DTR_REMOTE_STATUS_FOLLOW: terminal_ready <= (accept_active || connect_active) && remote_dsr;
                DTR_CONNECTED: terminal_ready <= accept_active || connect_active;
                DTR_ALWAYS: terminal_ready <= 1'b1;
                default: terminal_ready <= 1'b0;
            endcase
        end
    end

    a_pass_release: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && pack_mode == PACK_OFF |=> state == ST_DRAIN && count == 1 ##1 tx_valid && tx_last)
        else $error("unpacked byte not forwarded alone");
    a_thresh_release: assert property (@(posedge core_clk) disable iff (!reset_n)
        thresh_hit |-> ##[1:2] state == ST_DRAIN)
        else $error("threshold did not release the queue");
    a_queue_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_FILL && pack_mode == PACK_TIMEOUT && !release_now |=> state == ST_FILL)
        else $error("queue released without cause");
    a_send_char: assert property (@(posedge core_clk) disable iff (!reset_n)
        char_hit |=> count == $past(next_count) && state != ST_FILL)
        else $error("send character did not release the queue with itself");
    a_trail_insert: assert property (@(posedge core_clk) disable iff (!reset_n)
        char_hit && trail_en |=> state == ST_TRAIL ##1 state == ST_DRAIN && count == $past(count) + 1)
        else $error("trailing byte not appended");
    a_no_trail: assert property (@(posedge core_clk) disable iff (!reset_n)
        char_hit && !trail_en |=> state == ST_DRAIN)
        else $error("trailing byte inserted while disabled");
    a_timer_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        timer_start && !release_now |=> timer_run && timer_ms == $past(timeout[14:0]))
        else $error("timer not started on first byte");
    a_release_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        drain_done |=> count == 0 && !timer_run && state == ST_FILL)
        else $error("release did not clear count and timer");
    a_dtr_connected: assert property (@(posedge core_clk) disable iff (!reset_n)
        dtr_policy == DTR_CONNECTED |=> terminal_ready == $past(accept_active || connect_active))
        else $error("terminal-ready does not track connection");
    a_dtr_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
        dtr_policy == DTR_REMOTE_STATUS_FOLLOW && !remote_dsr |=> !terminal_ready)
        else $error("terminal-ready high without remote DSR");

endmodule

// >>> src/packing_consts.svh
// constants for the serial packing line control block
`ifndef PACKING_CONSTS_SVH
`define PACKING_CONSTS_SVH

`define CLK_PERIOD_NS 50
`define MS_PERIOD_NS 1000000
`define MS_CYCLES (`MS_PERIOD_NS / `CLK_PERIOD_NS)

`define QUEUE_AW 11
`define QUEUE_DEPTH 2048
`define CFG_W 16

`define THRESH_MIN 16'h0064
`define THRESH_MAX 16'h05AA
`define THRESH_DEFAULT 16'h0200
`define TIMEOUT_MIN 16'h0001
`define TIMEOUT_MAX 16'h7530
`define TIMEOUT_DEFAULT 16'h03E8

`endif

// >>> src/packing_pkg.sv
// types shared by the serial packing line control block
package packing_pkg;
    typedef enum logic [1:0] {
        PACK_OFF,
        PACK_TIMEOUT,
        PACK_SEND_CHAR
    } pack_mode_t;

    typedef enum logic [1:0] {
        DTR_NEVER,
        DTR_REMOTE_STATUS_FOLLOW,
        DTR_CONNECTED,
        DTR_ALWAYS
    } dtr_policy_t;

    typedef enum logic [1:0] {
        ST_FILL,
        ST_TRAIL,
        ST_DRAIN
    } pack_state_t;
endpackage

// >>> dv/net_sink.sv
// network transmit path model: takes segment bytes, stalls on request, logs bytes and segment ends
`timescale 1ns/10ps
module net_sink (
    input wire logic core_clk,      // clock
    input wire logic reset_n,       // async reset, active low
    input wire logic tx_valid,      // byte offered
    input wire logic [7:0] tx_data, // byte
    input wire logic tx_last,       // segment end
    input wire logic slow,          // take only every other cycle
    output logic tx_ready           // byte taken
);
    logic [7:0] got[$];
    int n_seg = 0;
    // stalling proves the block holds its byte across refused cycles
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            tx_ready <= 1'b0;
        else
            tx_ready <= slow ? !tx_ready : 1'b1;
    end
    always @(posedge core_clk) begin
        if (reset_n && tx_valid && tx_ready) begin
            got.push_back(tx_data);
            n_seg += tx_last;
        end
    end
endmodule

// >>> dv/tb.sv
// self-checking testbench for the packing and terminal-ready block
`timescale 1ns/10ps
module tb;
    import packing_pkg::*;
    logic core_clk = 0, reset_n = 0, rx_valid = 0, slow = 0, rx_ready, tx_valid, tx_last, tx_ready, terminal_ready;
    logic trail_en = 0, accept_active = 0, connect_active = 0, remote_dsr = 0;
    logic [7:0] rx_data = 0, tx_data, send_char = 0, trail_char = 0;
    logic [15:0] thresh_cfg = 16'h0200, timeout_cfg = 16'h03e8;
    pack_mode_t pack_mode = PACK_OFF;
    dtr_policy_t dtr_policy = DTR_NEVER;
    int n_fail = 0, checks_done = 0, segs = 0, seg_wait = 0;
    logic [7:0] q[$];

    serial_packing_line_control #(.MS_CYCLES(4)) serial_packing_line_control_i (.core_clk(core_clk),
        .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .pack_mode(pack_mode), .thresh_cfg(thresh_cfg),
        .timeout_cfg(timeout_cfg), .send_char(send_char), .trail_en(trail_en), .trail_char(trail_char),
        .dtr_policy(dtr_policy), .accept_active(accept_active), .connect_active(connect_active),
        .remote_dsr(remote_dsr), .terminal_ready(terminal_ready));
    net_sink net_sink_i (.core_clk(core_clk), .reset_n(reset_n), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .slow(slow), .tx_ready(tx_ready));

    always #25 core_clk = !core_clk;

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    task send(input logic [7:0] b);
        rx_valid <= 1'b1;
        rx_data <= b;
        do @(posedge core_clk); while (rx_ready !== 1'b1);
    endtask
    task idle(input int n);
        rx_valid <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    // waits for the next segment end, then compares its bytes in order
    task seg(input logic [7:0] exp[$]);
        int k;
        k = 0;
        while (net_sink_i.n_seg <= segs && k < 2000) begin
            @(posedge core_clk);
            k++;
        end
        segs++;
        seg_wait = k;
        chk(32'(k < 2000), 32'h0000_0001, "segment timeout");
        chk(net_sink_i.got.size(), exp.size(), "segment length");
        foreach (exp[i]) chk(net_sink_i.got[i], exp[i], "segment byte");
        net_sink_i.got.delete();
    endtask
    task t_off();
        pack_mode <= PACK_OFF;
        slow <= 1'b1;
        send(8'h5a);
        idle(1);
        seg('{8'h5a});
        send(8'ha5);
        idle(1);
        seg('{8'ha5});
        slow <= 1'b0;
        $display("test off done");
    endtask
    task t_char();
        pack_mode <= PACK_SEND_CHAR;
        send_char <= 8'h0d;
        trail_en <= 1'b1;
        trail_char <= 8'h0a;
        accept_active <= 1'b1;
        send(8'h11);
        send(8'h22);
        send(8'h0d);
        idle(1);
        seg('{8'h11, 8'h22, 8'h0d, 8'h0a});
        trail_en <= 1'b0;
        send_char <= 8'h00;
        send(8'h33);
        send(8'h00);
        idle(1);
        seg('{8'h33, 8'h00});
        $display("test send char done");
    endtask
    task t_time();
        pack_mode <= PACK_TIMEOUT;
        timeout_cfg <= 16'h0002;
        accept_active <= 1'b0;
        connect_active <= 1'b1;
        send(8'h41);
        send(8'h42);
        // a release one millisecond early would already have ended its segment here
        idle(8);
        chk(net_sink_i.n_seg, segs, "early timeout release");
        seg('{8'h41, 8'h42});
        chk(32'(seg_wait <= 4), 32'h0000_0001, "late timeout release");
        send(8'h43);
        idle(8);
        chk(net_sink_i.n_seg, segs, "timer not restarted");
        seg('{8'h43});
        chk(32'(seg_wait <= 4), 32'h0000_0001, "restarted timer late");
        $display("test timeout done");
    endtask
    task t_thresh();
        // below-range threshold is clamped up to the minimum of 100 bytes
        thresh_cfg <= 16'h0005;
        timeout_cfg <= 16'h7530;
        q.delete();
        for (int i = 0; i < 100; i++) q.push_back(i[7:0]);
        for (int i = 0; i < 99; i++) send(q[i]);
        idle(4);
        chk(net_sink_i.n_seg, segs, "release before threshold");
        send(q[99]);
        idle(1);
        seg(q);
        $display("test threshold done");
    endtask
    task t_dtr();
        logic a, c, d, e;
        for (int p = 0; p < 4; p++) begin
            for (int v = 0; v < 8; v++) begin
                {a, c, d} = v[2:0];
                dtr_policy <= dtr_policy_t'(p[1:0]);
                accept_active <= a;
                connect_active <= c;
                remote_dsr <= d;
                repeat (2) @(posedge core_clk);
                e = (p == 3) || (p == 2 && (a || c)) || (p == 1 && (a || c) && d);
                chk(terminal_ready, e, "terminal ready");
            end
        end
        $display("test terminal ready done");
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        t_off();
        t_char();
        t_time();
        t_thresh();
        t_dtr();
        conclude();
    end
    // all tests together need a few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        conclude();
    end
endmodule
